// file: sdcd_defs.vh
/*
  Constants for the SDRAM command decoder: pin field positions, command
  pattern codes, power states and burst settings.
  Assumes inclusion by bare name from the decoder, checker and bench files.
*/
`ifndef SDCD_DEFS_VH
`define SDCD_DEFS_VH

// ----------------------------------------
// Address bus layout
// ----------------------------------------
`define SDCD_ADDR_W 18
`define SDCD_AP_BIT 10
`define SDCD_BC_BIT 12
`define SDCD_RFU_BIT 17
`define SDCD_OP_W 17
`define SDCD_ROW_LO_W 14
`define SDCD_COL_W 10

// ----------------------------------------
// Row/column/write pattern codes {ras,cas,we}
// ----------------------------------------
`define SDCD_PAT_MRS 3'h0
`define SDCD_PAT_REF 3'h1
`define SDCD_PAT_PRE 3'h2
`define SDCD_PAT_RFU 3'h3
`define SDCD_PAT_WR 3'h4
`define SDCD_PAT_RD 3'h5
`define SDCD_PAT_ZQ 3'h6
`define SDCD_PAT_NOP 3'h7

// ----------------------------------------
// Decoded command codes
// ----------------------------------------
`define SDCD_CMD_W 5
`define SDCD_C_NONE 5'h00
`define SDCD_C_DES 5'h01
`define SDCD_C_NOP 5'h02
`define SDCD_C_MRS 5'h03
`define SDCD_C_REF 5'h04
`define SDCD_C_SR_ENTRY 5'h05
`define SDCD_C_SR_EXIT 5'h06
`define SDCD_C_PRE 5'h07
`define SDCD_C_PREA 5'h08
`define SDCD_C_ACT 5'h09
`define SDCD_C_WR 5'h0a
`define SDCD_C_WRA 5'h0b
`define SDCD_C_RD 5'h0c
`define SDCD_C_RDA 5'h0d
`define SDCD_C_ZQL 5'h0e
`define SDCD_C_ZQS 5'h0f
`define SDCD_C_PD_ENTRY 5'h10
`define SDCD_C_PD_EXIT 5'h11

// ----------------------------------------
// Power states and burst
// ----------------------------------------
`define SDCD_ST_IDLE 2'h0
`define SDCD_ST_PD 2'h1
`define SDCD_ST_SR 2'h2
`define SDCD_BEATS_W 4
`define SDCD_BEATS_BL8 4'h8
`define SDCD_BEATS_BC4 4'h4
`define SDCD_BEAT_ONE 4'h1

`endif

// file: sdcd_decoder.v
/*
  SDRAM command decoder: samples command/address pins each rising clock
  edge and resolves them into one-cycle command pulses and power state.
  Assumes the controller drives valid pins synchronous to clk_sys_i and
  holds resetn_i high while commands run.
*/
// Functional notes
// RULE1: Decode CS, ACT, command pins, CKE per edge
// RULE2: ACT high: pins act as command strobes
// RULE3: CS and ACT low: activate, pins are A16-A14
// RULE4: Decode MRS, refresh, precharge, reserved, ZQ
// RULE5: MRS: bank group/bank pick register, address opcode
// RULE6: MRS address bit 17 not opcode data
// RULE7: HLL write, HLH read, bit10 auto-precharge
// RULE8: Mode register fixes or flies burst; bit12 chop
// RULE9: Started bursts always complete uninterrupted
// RULE10: Controller drives valid inputs; don't-cares ignored
// RULE11: Active-low reset only; held high during commands
// RULE12: Self-refresh entry/exit by CKE edge with pattern
// RULE13: Self-refresh exit detected synchronously here
// RULE14: Power-down entry/exit by CKE edge, CS high
// RULE15: No refresh while in power-down
// RULE16: Controller uses NOP only in allowed modes
// RULE17: Controller never substitutes NOP for deselect
// RULE18: Address MSBs sized by density configuration
// RULE19: Termination input never affects decoding
// RULE20: Termination disabled throughout self refresh
// RULE21: Reserved or unlisted patterns do nothing
`timescale 1ns/1ps
`default_nettype none
`include "sdcd_defs.vh"

module sdcd_decoder
(
  // Clock and reset
  input wire clk_sys_i,
  input wire resetn_i,
  // Command pins
  input wire cke_i,
  input wire cs_n_i,
  input wire act_n_i,
  input wire ras_n_a16_i,
  input wire cas_n_a15_i,
  input wire we_n_a14_i,
  input wire [1:0] bg_i,
  input wire [1:0] ba_i,
  input wire [`SDCD_ADDR_W-1:0] addr_i,
  input wire odt_i,
  // Burst configuration from the mode registers
  input wire burst_otf_en_i,
  input wire burst_fixed_chop_i,
  // Decoded command
  output reg [`SDCD_CMD_W-1:0] cmd_o,
  output reg cmd_valid_o,
  output reg [1:0] bg_o,
  output reg [1:0] ba_o,
  output reg [`SDCD_ADDR_W-1:0] row_o,
  output reg [9:0] col_o,
  output reg [`SDCD_OP_W:0] mrs_op_o,
  output reg [2:0] mrs_sel_o,
  output reg chop_four_on_the_fly_o,
  output reg burst_eight_on_the_fly_o,
  output reg [`SDCD_BEATS_W-1:0] burst_beats_o,
  // Device state
  output reg burst_busy_o,
  output reg powerdown_o,
  output reg selfrefresh_o,
  output reg refresh_allowed_o,
  output reg odt_enable_o
);

  // ----------------------------------------
  // Power states
  // ----------------------------------------
  localparam [1:0] ST_IDLE = `SDCD_ST_IDLE;
  localparam [1:0] ST_PD = `SDCD_ST_PD;
  localparam [1:0] ST_SR = `SDCD_ST_SR;

  // ----------------------------------------
  // Pattern classification
  // ----------------------------------------
  reg cke_prev_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`SDCD_BEATS_W-1:0] beats_q;
  reg [`SDCD_CMD_W-1:0] cmd_d;
  wire [2:0] pat = {ras_n_a16_i, cas_n_a15_i, we_n_a14_i};
  wire ap = addr_i[`SDCD_AP_BIT];
  wire bc_n = addr_i[`SDCD_BC_BIT];
  wire cke_rise = ~cke_prev_q & cke_i;
  wire cke_fall = cke_prev_q & ~cke_i;
  wire cke_hold = cke_prev_q & cke_i;

  // Choose between two codes on the auto-precharge or calibration bit
  function [`SDCD_CMD_W-1:0] sel_ap;
    input bit_v;
    input [`SDCD_CMD_W-1:0] hi_c;
    input [`SDCD_CMD_W-1:0] lo_c;
    begin
      sel_ap = bit_v ? hi_c : lo_c;
    end
  endfunction

  // Termination level deliberately takes no part in this decode
  always @* // RULE1 RULE19
  begin
    cmd_d = `SDCD_C_NONE;
    if (cke_fall && state_q == ST_IDLE)
    begin
      if (cs_n_i)
        cmd_d = `SDCD_C_PD_ENTRY; // RULE14
      else if (!act_n_i && pat == `SDCD_PAT_REF)
        cmd_d = `SDCD_C_NONE;
      else if (act_n_i && pat == `SDCD_PAT_REF)
        cmd_d = `SDCD_C_SR_ENTRY; // RULE12
    end
    else if (cke_rise)
    begin
      // Exit sampled on the clock; an asynchronous path is not needed
      if (state_q == ST_SR && (cs_n_i || (act_n_i && pat == `SDCD_PAT_NOP)))
        cmd_d = `SDCD_C_SR_EXIT; // RULE12 RULE13
      else if (state_q == ST_PD && cs_n_i)
        cmd_d = `SDCD_C_PD_EXIT; // RULE14
    end
    else if (cke_hold && state_q == ST_IDLE)
    begin
      if (cs_n_i)
        cmd_d = `SDCD_C_DES;
      else if (!act_n_i)
        cmd_d = `SDCD_C_ACT; // RULE3
      else
      begin
        case (pat) // RULE2 RULE4 RULE7
          `SDCD_PAT_MRS: cmd_d = `SDCD_C_MRS;
          `SDCD_PAT_REF: cmd_d = `SDCD_C_REF;
          `SDCD_PAT_PRE: cmd_d = sel_ap(ap, `SDCD_C_PREA, `SDCD_C_PRE);
          `SDCD_PAT_WR: cmd_d = sel_ap(ap, `SDCD_C_WRA, `SDCD_C_WR);
          `SDCD_PAT_RD: cmd_d = sel_ap(ap, `SDCD_C_RDA, `SDCD_C_RD);
          `SDCD_PAT_ZQ: cmd_d = sel_ap(ap, `SDCD_C_ZQL, `SDCD_C_ZQS);
          `SDCD_PAT_NOP: cmd_d = `SDCD_C_NOP;
          default: cmd_d = `SDCD_C_NONE; // RULE21
        endcase
      end
    end
  end

  // True for the four read and write codes that launch a data burst
  function is_burst_cmd;
    input [`SDCD_CMD_W-1:0] code;
    begin
      is_burst_cmd = (code == `SDCD_C_WR) || (code == `SDCD_C_WRA) ||
                     (code == `SDCD_C_RD) || (code == `SDCD_C_RDA);
    end
  endfunction

  // True for every code that is reported to the core
  function cmd_listed;
    input [`SDCD_CMD_W-1:0] code;
    begin
      cmd_listed = (code != `SDCD_C_NONE);
    end
  endfunction

  wire is_rw = is_burst_cmd(cmd_d);
  wire chop = burst_otf_en_i ? ~bc_n : burst_fixed_chop_i; // RULE8
  wire [`SDCD_BEATS_W-1:0] beats_new = chop ? `SDCD_BEATS_BC4 : `SDCD_BEATS_BL8;

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (cmd_d == `SDCD_C_PD_ENTRY)
          state_d = ST_PD;
        else if (cmd_d == `SDCD_C_SR_ENTRY)
          state_d = ST_SR;
      end
      ST_PD:
        if (cmd_d == `SDCD_C_PD_EXIT)
          state_d = ST_IDLE;
      ST_SR:
        if (cmd_d == `SDCD_C_SR_EXIT)
          state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // Power state registers
  // ----------------------------------------
  always @(posedge clk_sys_i)
  begin
    if (!resetn_i) // RULE11
    begin
      cke_prev_q <= 1'b0;
      state_q <= ST_IDLE;
      powerdown_o <= 1'b0;
      selfrefresh_o <= 1'b0;
      refresh_allowed_o <= 1'b1;
      odt_enable_o <= 1'b1;
    end
    else
    begin
      cke_prev_q <= cke_i;
      state_q <= state_d;
      powerdown_o <= (state_d == ST_PD);
      selfrefresh_o <= (state_d == ST_SR);
      refresh_allowed_o <= (state_d == ST_IDLE); // RULE15
      odt_enable_o <= (state_d != ST_SR); // RULE20
    end
  end

  // ----------------------------------------
  // Command strobe
  // ----------------------------------------
  always @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      cmd_o <= `SDCD_C_NONE;
      cmd_valid_o <= 1'b0;
    end
    else
    begin
      cmd_o <= cmd_d;
      cmd_valid_o <= cmd_listed(cmd_d);
    end
  end

  // ----------------------------------------
  // Captured address fields
  // ----------------------------------------
  always @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      bg_o <= 2'h0;
      ba_o <= 2'h0;
      row_o <= {`SDCD_ADDR_W{1'b0}};
      col_o <= {`SDCD_COL_W{1'b0}};
      mrs_op_o <= {(`SDCD_OP_W+1){1'b0}};
      mrs_sel_o <= 3'h0;
    end
    else
    begin
      // Unlisted patterns leave every captured field untouched
      if (cmd_listed(cmd_d)) // RULE21
      begin
        bg_o <= bg_i;
        ba_o <= ba_i;
      end
      if (cmd_d == `SDCD_C_ACT)
        row_o <= {addr_i[`SDCD_RFU_BIT], ras_n_a16_i, cas_n_a15_i, we_n_a14_i,
                  addr_i[`SDCD_ROW_LO_W-1:0]}; // RULE3 RULE18
      if (cmd_d == `SDCD_C_MRS)
      begin
        mrs_sel_o <= {bg_i[0], ba_i}; // RULE5
        // Bit 17 is reserved for this density and is forced to zero
        mrs_op_o <= {1'b0, addr_i[`SDCD_OP_W-1:0]}; // RULE6
      end
      if (is_rw)
        col_o <= addr_i[`SDCD_COL_W-1:0]; // RULE7
    end
  end

  // ----------------------------------------
  // Burst tracking
  // ----------------------------------------
  // A read or write landing mid-burst is not queued; the controller spaces bursts
  always @(posedge clk_sys_i)
  begin
    if (!resetn_i)
    begin
      beats_q <= {`SDCD_BEATS_W{1'b0}};
      chop_four_on_the_fly_o <= 1'b0;
      burst_eight_on_the_fly_o <= 1'b0;
      burst_beats_o <= {`SDCD_BEATS_W{1'b0}};
      burst_busy_o <= 1'b0;
    end
    else
    begin
      // A burst in flight counts down regardless of later commands
      if (beats_q > `SDCD_BEAT_ONE) // RULE9
        beats_q <= beats_q - `SDCD_BEAT_ONE;
      else if (is_rw)
        beats_q <= beats_new;
      else
        beats_q <= {`SDCD_BEATS_W{1'b0}};
      if (is_rw)
      begin
        chop_four_on_the_fly_o <= burst_otf_en_i & ~bc_n; // RULE8
        burst_eight_on_the_fly_o <= burst_otf_en_i & bc_n; // RULE8
        burst_beats_o <= beats_new;
      end
      burst_busy_o <= is_rw || (beats_q > `SDCD_BEAT_ONE); // RULE9
    end
  end

endmodule // sdcd_decoder
`default_nettype wire

// file: sdcd_decoder_chk.sv
/* Assertions on the command decoder ports.
   Assumes one clock and the decoder as the bind target. */
`timescale 1ns/1ps
`default_nettype none
`include "sdcd_defs.vh"
module sdcd_decoder_chk (
  // Pins
  input wire logic clk_sys_i, resetn_i, cke_i, cs_n_i, act_n_i,
  input wire logic ras_n_a16_i, cas_n_a15_i, we_n_a14_i, burst_otf_en_i,
  input wire logic [1:0] bg_i, ba_i,
  input wire logic [17:0] addr_i,
  // Results
  input wire logic [4:0] cmd_o,
  input wire logic [17:0] row_o, mrs_op_o,
  input wire logic [9:0] col_o,
  input wire logic [2:0] mrs_sel_o,
  input wire logic [1:0] bg_o, ba_o,
  input wire logic [3:0] burst_beats_o,
  input wire logic cmd_valid_o, chop_four_on_the_fly_o, burst_eight_on_the_fly_o, burst_busy_o,
  input wire logic powerdown_o, selfrefresh_o, refresh_allowed_o, odt_enable_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  logic [2:0] pat_q;
  always_ff @(posedge clk_sys_i) pat_q <= {ras_n_a16_i, cas_n_a15_i, we_n_a14_i};
  // -----------------------
  // Decode steps
  // -----------------------
  // Two live edges needed: the design forgets the clock-enable history in reset
  sequence s_live; $past(resetn_i, 2) && $past(resetn_i) && !$past(powerdown_o) && !$past(selfrefresh_o); endsequence
  sequence s_sel; s_live ##0 ($past(cke_i, 2) && $past(cke_i) && !$past(cs_n_i)); endsequence
  sequence s_cmd; s_sel ##0 $past(act_n_i); endsequence
  a_valid_flag: assert property (s_live ##0 ($past(cke_i, 2) && $past(cke_i) && $past(cs_n_i))
    |-> cmd_o == `SDCD_C_DES && cmd_valid_o) else $error("deselect not flagged");
  a_act_row: assert property (s_sel ##0 !$past(act_n_i) |-> cmd_o == `SDCD_C_ACT
    && row_o[16:14] == pat_q && bg_o == $past(bg_i) && ba_o == $past(ba_i)) else $error("activate wrong");
  a_rfu_quiet: assert property (s_cmd ##0 pat_q == `SDCD_PAT_RFU |-> cmd_o == `SDCD_C_NONE && $stable(row_o))
    else $error("reserved acted");
  a_mrs_fields: assert property (s_cmd ##0 pat_q == `SDCD_PAT_MRS |-> cmd_o == `SDCD_C_MRS
    && mrs_op_o == {1'b0, $past(addr_i[16:0])} && mrs_sel_o == {$past(bg_i[0]), $past(ba_i)}) else $error("mrs wrong");
  a_rdwr_kind: assert property (s_cmd ##0 pat_q[2:1] == 2'h2 |-> cmd_o == (pat_q[0] ?
    ($past(addr_i[10]) ? `SDCD_C_RDA : `SDCD_C_RD) : ($past(addr_i[10]) ? `SDCD_C_WRA : `SDCD_C_WR))
    && chop_four_on_the_fly_o == ($past(burst_otf_en_i) && !$past(addr_i[12]))
    && burst_eight_on_the_fly_o == ($past(burst_otf_en_i) && $past(addr_i[12]))) else $error("rd/wr wrong");
  a_pd_entry: assert property (s_live ##0 ($past(cke_i, 2) && !$past(cke_i) && $past(cs_n_i))
    |-> cmd_o == `SDCD_C_PD_ENTRY && powerdown_o) else $error("pd entry wrong");
  a_sr_entry: assert property (s_live ##0 ($past(cke_i, 2) && !$past(cke_i) && !$past(cs_n_i) && $past(act_n_i)
    && pat_q == `SDCD_PAT_REF) |-> cmd_o == `SDCD_C_SR_ENTRY && selfrefresh_o) else $error("sr entry wrong");
  a_no_refresh_pd: assert property (powerdown_o |-> !refresh_allowed_o) else $error("refresh in pd");
  a_odt_off_sr: assert property (selfrefresh_o |-> !odt_enable_o) else $error("odt on in sr");
  a_burst_whole: assert property ($rose(burst_busy_o) && burst_beats_o == `SDCD_BEATS_BL8 |-> burst_busy_o[*7])
    else $error("burst cut short");
endmodule // sdcd_decoder_chk
bind sdcd_decoder sdcd_decoder_chk sdcd_decoder_chk_i (.clk_sys_i, .resetn_i, .cke_i, .cs_n_i, .act_n_i,
  .ras_n_a16_i, .cas_n_a15_i, .we_n_a14_i, .burst_otf_en_i, .bg_i, .ba_i, .addr_i, .cmd_o, .row_o, .mrs_op_o,
  .col_o, .mrs_sel_o, .burst_beats_o, .cmd_valid_o, .chop_four_on_the_fly_o, .burst_busy_o, .powerdown_o,
  .selfrefresh_o, .refresh_allowed_o, .odt_enable_o, .bg_o, .ba_o, .burst_eight_on_the_fly_o);
`default_nettype wire

// file: sdcd_ctrl_model.sv
/* Memory controller model driving the decoder pins.
   Assumes the bench calls send once per clock. */
`timescale 1ns/1ps
`default_nettype none
module sdcd_ctrl_model (
  // Clock
  input wire logic clk_sys_i,
  // Command pins
  output var logic cke_o, cs_n_o, act_n_o, ras_n_o, cas_n_o, we_n_o, odt_o,
  output var logic [1:0] bg_o, ba_o,
  output var logic [17:0] addr_o
);
  initial {cke_o, cs_n_o, act_n_o, ras_n_o, cas_n_o, we_n_o, odt_o, bg_o, ba_o, addr_o} = 29'h0;
  task automatic send(input logic ck, cs, ac, input logic [2:0] p, input logic [1:0] g, b, input logic [17:0] a);
    @(posedge clk_sys_i);
    cke_o <= ck;
    cs_n_o <= cs;
    odt_o <= 1'($urandom);
    // Deselected pins toggle so a stale level is never mistaken for a command
    if (cs)
      {act_n_o, ras_n_o, cas_n_o, we_n_o, bg_o, ba_o, addr_o} <= ~{act_n_o, ras_n_o, cas_n_o, we_n_o, bg_o, ba_o, addr_o};
    else
      {act_n_o, ras_n_o, cas_n_o, we_n_o, bg_o, ba_o, addr_o} <= {ac, p, g, b, a};
  endtask
endmodule // sdcd_ctrl_model
`default_nettype wire

// file: sdcd_decoder_test.sv
/* Self-checking bench for the command decoder.
   Assumes the controller model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "sdcd_defs.vh"
module sdcd_decoder_test;
  logic clk_sys_i = 0, resetn_i = 0, otf = 0, fchop = 0;
  logic [2:0] p;
  logic [17:0] a;
  wire cke, cs_n, act_n, ras, cas, we, odt, pd, sr, ref_ok, odt_en;
  wire [1:0] bg, ba;
  wire [17:0] addr, row;
  wire [9:0] col;
  wire [4:0] cmd;
  wire [3:0] beats;
  int mismatches = 0, total_checks = 0;
  sdcd_ctrl_model sdcd_ctrl_model_i (.clk_sys_i, .cke_o(cke), .cs_n_o(cs_n), .act_n_o(act_n), .ras_n_o(ras),
    .cas_n_o(cas), .we_n_o(we), .odt_o(odt), .bg_o(bg), .ba_o(ba), .addr_o(addr));
  sdcd_decoder sdcd_decoder_i (.clk_sys_i, .resetn_i, .cke_i(cke), .cs_n_i(cs_n), .act_n_i(act_n),
    .ras_n_a16_i(ras), .cas_n_a15_i(cas), .we_n_a14_i(we), .bg_i(bg), .ba_i(ba), .addr_i(addr), .odt_i(odt),
    .burst_otf_en_i(otf), .burst_fixed_chop_i(fchop), .cmd_o(cmd), .cmd_valid_o(), .bg_o(), .ba_o(),
    .row_o(row), .col_o(col), .mrs_op_o(), .mrs_sel_o(), .chop_four_on_the_fly_o(), .burst_eight_on_the_fly_o(),
    .burst_beats_o(beats), .burst_busy_o(), .powerdown_o(pd), .selfrefresh_o(sr), .refresh_allowed_o(ref_ok),
    .odt_enable_o(odt_en));
  initial forever #2 clk_sys_i = ~clk_sys_i;
  function automatic logic [4:0] exp_cmd(input logic [2:0] q, input logic ap);
    case (q)
      `SDCD_PAT_MRS: exp_cmd = `SDCD_C_MRS;
      `SDCD_PAT_REF: exp_cmd = `SDCD_C_REF;
      `SDCD_PAT_PRE: exp_cmd = ap ? `SDCD_C_PREA : `SDCD_C_PRE;
      `SDCD_PAT_WR: exp_cmd = ap ? `SDCD_C_WRA : `SDCD_C_WR;
      `SDCD_PAT_RD: exp_cmd = ap ? `SDCD_C_RDA : `SDCD_C_RD;
      `SDCD_PAT_ZQ: exp_cmd = ap ? `SDCD_C_ZQL : `SDCD_C_ZQS;
      default: exp_cmd = `SDCD_C_NONE;
    endcase
  endfunction
  task automatic chk_val(input logic [17:0] got, exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_cmd(input logic [4:0] got, exp);
    chk_val(18'(got), 18'(exp));
  endtask
  // Command edge, then a deselect that keeps the clock-enable level
  task automatic issue(input logic ck, cs, ac, input logic [2:0] q, input logic [17:0] d, input logic [4:0] e);
    sdcd_ctrl_model_i.send(ck, cs, ac, q, 2'($urandom), 2'($urandom), d);
    sdcd_ctrl_model_i.send(ck, 1'b1, 1'b1, 3'h7, 2'h0, 2'h0, 18'h0);
    #1;
    chk_cmd(cmd, e);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #40000;
    mismatches++;
    stop_test;
  end
  initial
  begin
    void'($urandom(33277));
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    sdcd_ctrl_model_i.send(1'b1, 1'b1, 1'b1, 3'h7, 2'h0, 2'h0, 18'h0);
    repeat (48)
    begin
      p = 3'($urandom % 7);
      a = 18'($urandom);
      @(posedge clk_sys_i);
      otf <= 1'($urandom);
      fchop <= 1'($urandom);
      issue(1'b1, 1'b0, 1'b1, p, a, exp_cmd(p, a[10]));
      if (p[2:1] == 2'h2)
      begin
        chk_val(18'(col), 18'(a[9:0]));
        chk_val(18'(beats), otf ? (a[12] ? 18'h8 : 18'h4) : (fchop ? 18'h4 : 18'h8));
      end
      repeat (8) @(posedge clk_sys_i);
    end
    $display("test decode done");
    for (int i = 0; i < 8; i++)
    begin
      a = 18'($urandom);
      issue(1'b1, 1'b0, 1'b0, 3'(i), a, `SDCD_C_ACT);
      chk_val(row, {a[17], 3'(i), a[13:0]});
    end
    issue(1'b1, 1'b0, 1'b1, `SDCD_PAT_NOP, 18'h0, `SDCD_C_NOP);
    $display("test activate done");
    issue(1'b0, 1'b1, 1'b1, 3'h7, 18'h0, `SDCD_C_PD_ENTRY);
    chk_val(18'({pd, ref_ok}), 18'h2);
    issue(1'b0, 1'b0, 1'b1, `SDCD_PAT_REF, 18'h0, `SDCD_C_NONE);
    issue(1'b1, 1'b1, 1'b1, 3'h7, 18'h0, `SDCD_C_PD_EXIT);
    for (int i = 0; i < 2; i++)
    begin
      issue(1'b0, 1'b0, 1'b1, `SDCD_PAT_REF, 18'h0, `SDCD_C_SR_ENTRY);
      chk_val(18'({sr, odt_en}), 18'h2);
      issue(1'b1, 1'(i), 1'b1, 3'h7, 18'h0, `SDCD_C_SR_EXIT);
      chk_val(18'({pd, sr}), 18'h0);
    end
    $display("test power done");
    stop_test;
  end
endmodule // sdcd_decoder_test
`default_nettype wire
